// ===== cpu_op_subset_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpuop_consts.vh"

module cpu_op_subset_exec_tb;
  logic                   pclk, presetn, psel, penable, pwrite, wake;
  logic                   chk_r, pready, pslverr, stack_pop;
  logic                   watchdog_clear, osc_stop, d;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd, cmd, st;
  logic [32:0]            e;
  logic [`CPUOP_PC_W-1:0] stack_top, pc, pc_m;
  logic [7:0]             watchdog_load, acc, f, k, r;
  logic [4:0]             fl;
  logic [3:0]             op;
  logic [6:0]             fa;
  logic [32:0]            exp_q [$];
  int                     n_fail, checked, i, n;

  cpuop_exec u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .stack_top, .stack_pop, .pc,
    .watchdog_clear, .watchdog_load, .osc_stop, .wake);

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ***********
  // bus helpers
  // ***********
  // compare {error, read data} at the completing edge with the oldest note
  always @(posedge pclk) begin
    if (chk_r && psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      checked++;
      if ({pslverr, prdata} !== e) begin
        n_fail++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, {pslverr, prdata});
      end
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tmo();
    n_fail++;
    conclude();
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dv, input logic c);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    chk_r <= c;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50)
      tmo();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_r <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [32:0] ev);
    exp_q.push_back(ev);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask

  // poll busy; a fixed wait would hide a stuck command
  task automatic idle();
    n = 0;
    do begin
      apb(1'b0, `CPUOP_OFS_STAT, 32'h0, 1'b0);
      n++;
    end while (rd[`CPUOP_ST_BUSY] !== 1'b0 && n < 40);
    if (n >= 40)
      tmo();
  endtask

  task automatic sleep_wake();
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (osc_stop !== 1'b1 && n < 20);
    if (n >= 20)
      tmo();
    repeat (3) @(posedge pclk);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
  endtask

  // **************
  // main sequence
  // **************
  initial begin
    {presetn, psel, penable, pwrite, wake, chk_r} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    stack_top = '0;
    pc_m = '0;
    n_fail = 0;
    checked = 0;
    void'($urandom(20));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`CPUOP_OFS_STAT, 32'h18);
    rchk(`CPUOP_OFS_PC, 32'h0);
    apb(1'b1, 12'h020, 32'hFF, 1'b0);
    rchk(12'h018, 33'h100000000); // hole in the map: error, data 0
    rchk(`CPUOP_OFS_ACC, 32'h0);
    $display("test reset and map done");
    for (i = 0; i < 60; i++) begin
      op = (i % 10 == 9) ? 4'(9 + $urandom % 7) : 4'(i % 10);
      {d, fa, k, acc, f, fl} = 37'($urandom) ^ {37'($urandom) << 16};
      stack_top <= `CPUOP_PC_W'($urandom);
      apb(1'b1, `CPUOP_OFS_ACC, {24'h0, acc}, 1'b0);
      apb(1'b1, `CPUOP_OFS_FADDR, {25'h0, fa}, 1'b0);
      apb(1'b1, `CPUOP_OFS_FDATA, {24'h0, f}, 1'b0);
      apb(1'b1, `CPUOP_OFS_STAT, {27'h0, fl}, 1'b0);
      cmd = {8'h0, k, 1'b0, fa, 3'b0, d, op};
      r = acc;
      // reference result; flags {timeout, sleep, zero, nibble, carry}
      case (op)
        `CPUOP_OP_HALT: fl[4:3] = 2'b10;
        `CPUOP_OP_RETURN: pc_m = stack_top;
        `CPUOP_OP_LITSUB: begin
          r = k - acc;
          fl[1:0] = {k[3:0] >= acc[3:0], k >= acc};
        end
        `CPUOP_OP_RRC: {r, fl[0]} = {fl[0], f};
        `CPUOP_OP_FILESUB: begin
          r = f - acc;
          fl[1:0] = {f[3:0] >= acc[3:0], f >= acc};
        end
        `CPUOP_OP_SWAP: r = {f[3:0], f[7:4]};
        `CPUOP_OP_XORF: r = acc ^ f;
        `CPUOP_OP_XORL: r = acc ^ k;
        `CPUOP_OP_RLC: {fl[0], r} = {f, fl[0]};
        default: ;
      endcase
      if (op inside {4'h2, 4'h4, 4'h6, 4'h7})
        fl[2] = (r == 8'h00);
      if (op >= 4'h2 && op <= 4'h8) begin
        if (d && op != `CPUOP_OP_LITSUB && op != `CPUOP_OP_XORL)
          f = r;
        else
          acc = r;
      end
      apb(1'b1, `CPUOP_OFS_CMD, cmd, 1'b0);
      // first poll after a command: only a return is still busy
      st = {23'h0, op == `CPUOP_OP_RETURN, 3'h0, fl};
      if (op == `CPUOP_OP_HALT)
        sleep_wake();
      else
        rchk(`CPUOP_OFS_STAT, st);
      idle();
      rchk(`CPUOP_OFS_ACC, {24'h0, acc});
      rchk(`CPUOP_OFS_FDATA, {24'h0, f});
      rchk(`CPUOP_OFS_STAT, {27'h0, fl});
      rchk(`CPUOP_OFS_PC, {19'h0, pc_m});
    end
    $display("test operations done");
    conclude();
  end

  // hang guard
  initial begin
    #200000;
    tmo();
  end
endmodule
`default_nettype wire

// ===== cpuop_consts.vh
// Behaviour
// - halt clears the watchdog counter and its prescaler to zero
// - halt clears sleep_entered_flag, sets timeout_status, nothing else
// - after halt updates, enter sleep with the main oscillator stopped
// - subroutine exit pops stack, stack_top into pc, flags kept
// - subroutine exit takes two instruction cycles
// - literal minus accumulator into accumulator; carry, nibble, zero
// - rotate right through carry; old carry to bit 7, bit 0 to carry
// - file minus accumulator to destination; carry, nibble, zero
// - nibble exchange swaps file nibbles, no flag changes
// - accumulator xor file to destination, updates only zero flag
// - accumulator xor literal into accumulator, updates only zero flag
// - destination bit 0 writes accumulator, 1 writes the file register
// - rotate left through carry; old carry to bit 0, bit 7 to carry
`ifndef CPUOP_CONSTS_VH
`define CPUOP_CONSTS_VH

// ******************************
// apb register byte offsets
// ******************************
`define CPUOP_OFS_CMD    12'h000
`define CPUOP_OFS_ACC    12'h004
`define CPUOP_OFS_STAT   12'h008
`define CPUOP_OFS_FADDR  12'h00C
`define CPUOP_OFS_FDATA  12'h010
`define CPUOP_OFS_PC     12'h014

// ******************************
// command word fields
// ******************************
`define CPUOP_CMD_OP_LSB    0
`define CPUOP_CMD_OP_MSB    3
`define CPUOP_CMD_DEST_BIT  4
`define CPUOP_CMD_FA_LSB    8
`define CPUOP_CMD_FA_MSB    14
`define CPUOP_CMD_LIT_LSB   16
`define CPUOP_CMD_LIT_MSB   23

// ******************************
// status word fields
// ******************************
`define CPUOP_ST_CARRY    0
`define CPUOP_ST_NIBBLE   1
`define CPUOP_ST_ZERO     2
`define CPUOP_ST_SLEEPN   3
`define CPUOP_ST_TIMEOUT  4
`define CPUOP_ST_BUSY     8
`define CPUOP_ST_ASLEEP   9

// ******************************
// operation codes
// ******************************
`define CPUOP_OP_HALT     4'h0
`define CPUOP_OP_RETURN   4'h1
`define CPUOP_OP_LITSUB   4'h2
`define CPUOP_OP_RRC      4'h3
`define CPUOP_OP_FILESUB  4'h4
`define CPUOP_OP_SWAP     4'h5
`define CPUOP_OP_XORF     4'h6
`define CPUOP_OP_XORL     4'h7
`define CPUOP_OP_RLC      4'h8

// ******************************
// reset values and sizes
// ******************************
`define CPUOP_RST_ACC     8'h00
`define CPUOP_RST_FLAGS   5'h18
`define CPUOP_RST_PC      13'h0000
`define CPUOP_WDT_ZERO    8'h00
`define CPUOP_PC_W        13
`define CPUOP_FILE_DEPTH  128

`endif

// ===== cpuop_exec.v
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cpuop_consts.vh"

module cpuop_exec (
  // apb slave
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [11:0]             paddr,
  input  wire [31:0]             pwdata,
  output wire                    pready,
  output wire                    pslverr,
  output wire [31:0]             prdata,
  // return stack
  input  wire [`CPUOP_PC_W-1:0]  stack_top,
  output wire                    stack_pop,
  output wire [`CPUOP_PC_W-1:0]  pc,
  // watchdog and power
  output wire                    watchdog_clear,
  output wire [7:0]              watchdog_load,
  output wire                    osc_stop,
  input  wire                    wake
);

  // ******************************
  // states, one-hot
  // ******************************
  // one-hot keeps the busy and sleep decodes to a single bit each
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_EXEC  = 4'b0010;
  localparam [3:0] ST_RET2  = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;

  // ******************************
  // storage
  // ******************************
  reg  [3:0]             state_r;
  reg  [3:0]             state_nxt;
  reg  [7:0]             acc_r;
  // file registers are plain flops indexed by the 7-bit address
  reg  [7:0]             file_r [0:`CPUOP_FILE_DEPTH-1];
  reg  [6:0]             faddr_r;
  reg  [`CPUOP_PC_W-1:0] pc_r;
  reg                    carry_r;
  reg                    nibble_carry_flag_r;
  reg                    zero_r;
  reg                    sleep_entered_flag_r;
  reg                    timeout_status_r;
  reg  [3:0]             op_r;
  reg                    dest_r;
  reg  [6:0]             fa_r;
  reg  [7:0]             lit_r;
  reg  [31:0]            prdata_r;
  reg                    pop_r;
  reg                    wdclr_r;
  integer                i;

  // ******************************
  // subtract with borrow flags
  // ******************************
  // returns {carry, nibble carry, difference}; carry means no borrow
  // compares give both borrows without a second, nine-bit adder
  function [9:0] sub8;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] d;
    begin
      d     = a - b;
      sub8  = {(a >= b), (a[3:0] >= b[3:0]), d};
    end
  endfunction

  // ******************************
  // apb decode
  // ******************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire hit_cmd = (paddr == `CPUOP_OFS_CMD);
  wire hit_acc = (paddr == `CPUOP_OFS_ACC);
  wire hit_st  = (paddr == `CPUOP_OFS_STAT);
  wire hit_fa  = (paddr == `CPUOP_OFS_FADDR);
  wire hit_fd  = (paddr == `CPUOP_OFS_FDATA);
  wire hit_pc  = (paddr == `CPUOP_OFS_PC);
  wire mapped  = hit_cmd | hit_acc | hit_st | hit_fa | hit_fd | hit_pc;
  wire busy    = ~state_r[0];
  // pslverr marks holes in the map only; busy drops are silent
  wire wr      = access & pwrite & mapped;
  // writes that would race the datapath are dropped while busy
  wire wr_ok   = wr & ~busy;
  wire start   = wr_ok & hit_cmd;

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // ******************************
  // operand fetch and result compute
  // ******************************
  // the file operand is read straight from the latched address
  wire [7:0] fval = file_r[fa_r];
  wire [9:0] lsub = sub8(lit_r, acc_r);
  wire [9:0] fsub = sub8(fval, acc_r);
  reg  [7:0] res;
  reg        res_c;
  reg        res_dc;
  reg        upd_c;
  reg        upd_dc;
  reg        upd_z;
  reg        to_acc;
  reg        to_file;

  // result mux; flags gated per operation
  always @* begin
    res     = 8'h00;
    res_c   = carry_r;
    res_dc  = nibble_carry_flag_r;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    to_acc  = 1'b0;
    to_file = 1'b0;
    case (op_r)
      `CPUOP_OP_LITSUB: begin
        res    = lsub[7:0];
        res_c  = lsub[9];
        res_dc = lsub[8];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
        to_acc = 1'b1;
      end
      `CPUOP_OP_FILESUB: begin
        res    = fsub[7:0];
        res_c  = fsub[9];
        res_dc = fsub[8];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
        to_acc = ~dest_r;
        to_file = dest_r;
      end
      `CPUOP_OP_RRC: begin
        res    = {carry_r, fval[7:1]};
        res_c  = fval[0];
        upd_c  = 1'b1;
        to_acc = ~dest_r;
        to_file = dest_r;
      end
      `CPUOP_OP_RLC: begin
        res    = {fval[6:0], carry_r};
        res_c  = fval[7];
        upd_c  = 1'b1;
        to_acc = ~dest_r;
        to_file = dest_r;
      end
      `CPUOP_OP_SWAP: begin
        res    = {fval[3:0], fval[7:4]};
        to_acc = ~dest_r;
        to_file = dest_r;
      end
      `CPUOP_OP_XORF: begin
        res    = acc_r ^ fval;
        upd_z  = 1'b1;
        to_acc = ~dest_r;
        to_file = dest_r;
      end
      `CPUOP_OP_XORL: begin
        res    = acc_r ^ lit_r;
        upd_z  = 1'b1;
        to_acc = 1'b1;
      end
      default: begin
        res    = 8'h00;
      end
    endcase
  end

  // exec is the one cycle in which results and flags land
  wire exec = state_r[1];

  // ******************************
  // sequencer
  // ******************************
  // halt and return take extra states; others finish in one exec cycle
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        if (op_r == `CPUOP_OP_HALT)
          state_nxt = ST_SLEEP;
        else if (op_r == `CPUOP_OP_RETURN)
          state_nxt = ST_RET2;
        else
          state_nxt = ST_IDLE;
      end
      ST_RET2: begin
        state_nxt = ST_IDLE;
      end
      // wake is a level; a pulse between two edges is missed
      ST_SLEEP: begin
        if (wake) state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ******************************
  // command latch
  // ******************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r   <= `CPUOP_OP_HALT;
      dest_r <= 1'b0;
      fa_r   <= 7'h00;
      lit_r  <= 8'h00;
    end else if (start) begin
      // fields latch once, so later bus writes cannot disturb the op
      op_r   <= pwdata[`CPUOP_CMD_OP_MSB:`CPUOP_CMD_OP_LSB];
      dest_r <= pwdata[`CPUOP_CMD_DEST_BIT];
      fa_r   <= pwdata[`CPUOP_CMD_FA_MSB:`CPUOP_CMD_FA_LSB];
      lit_r  <= pwdata[`CPUOP_CMD_LIT_MSB:`CPUOP_CMD_LIT_LSB];
    end
  end

  // ******************************
  // accumulator and file registers
  // ******************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r   <= `CPUOP_RST_ACC;
      faddr_r <= 7'h00;
      for (i = 0; i < `CPUOP_FILE_DEPTH; i = i + 1) begin
        file_r[i] <= 8'h00;
      end
    end else begin
      // the datapath has priority; software is locked out while busy
      if (exec & to_acc) begin
        acc_r <= res;
      end else if (wr_ok & hit_acc) begin
        acc_r <= pwdata[7:0];
      end
      if (exec & to_file) begin
        file_r[fa_r] <= res;
      end else if (wr_ok & hit_fd) begin
        file_r[faddr_r] <= pwdata[7:0];
      end
      if (wr_ok & hit_fa) begin
        faddr_r <= pwdata[6:0];
      end
    end
  end

  // ******************************
  // status flags
  // ******************************
  // the datapath owns the flags while busy; software writes only when idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {timeout_status_r, sleep_entered_flag_r, zero_r,
       nibble_carry_flag_r, carry_r} <= `CPUOP_RST_FLAGS;
    end else if (exec) begin
      if (upd_c) carry_r <= res_c;
      if (upd_dc) nibble_carry_flag_r <= res_dc;
      if (upd_z) zero_r <= (res == 8'h00);
      // halt moves only the two power flags; carry and zero keep
      if (op_r == `CPUOP_OP_HALT) begin
        sleep_entered_flag_r <= 1'b0;
        timeout_status_r     <= 1'b1;
      end
    end else if (wr_ok & hit_st) begin
      carry_r              <= pwdata[`CPUOP_ST_CARRY];
      nibble_carry_flag_r  <= pwdata[`CPUOP_ST_NIBBLE];
      zero_r               <= pwdata[`CPUOP_ST_ZERO];
      sleep_entered_flag_r <= pwdata[`CPUOP_ST_SLEEPN];
      timeout_status_r     <= pwdata[`CPUOP_ST_TIMEOUT];
    end
  end

  // ******************************
  // program counter, stack and watchdog strobes
  // ******************************
  // strobes are registered so stack and watchdog see clean pulses
  wire do_ret  = exec & (op_r == `CPUOP_OP_RETURN);
  wire do_halt = exec & (op_r == `CPUOP_OP_HALT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r    <= `CPUOP_RST_PC;
      pop_r   <= 1'b0;
      wdclr_r <= 1'b0;
    end else begin
      pop_r   <= do_ret;
      wdclr_r <= do_halt;
      if (do_ret) begin
        pc_r <= stack_top;
      end
    end
  end

  assign stack_pop      = pop_r;
  assign pc             = pc_r;
  assign watchdog_clear = wdclr_r;
  assign watchdog_load  = `CPUOP_WDT_ZERO;
  assign osc_stop       = state_r[3];

  // ******************************
  // read data
  // ******************************
  // captured in setup so the access phase returns a stable flop value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata_r <= 32'h00000000;
      if (hit_acc) prdata_r <= {24'h000000, acc_r};
      if (hit_st) begin
        prdata_r <= {22'h000000, state_r[3], busy, 3'h0,
                     timeout_status_r, sleep_entered_flag_r, zero_r,
                     nibble_carry_flag_r, carry_r};
      end
      if (hit_fa) prdata_r <= {25'h0000000, faddr_r};
      if (hit_fd) prdata_r <= {24'h000000, file_r[faddr_r]};
      if (hit_pc) prdata_r <= {19'h00000, pc_r};
      // command read-back shows the last latched operation
      if (hit_cmd) begin
        prdata_r <= {8'h00, lit_r, 1'b0, fa_r, 3'h0, dest_r, op_r};
      end
    end
  end

endmodule
`default_nettype wire

// ===== cpuop_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpuop_consts.vh"

module cpuop_chk (
  // clock, reset and apb
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [31:0]            prdata,
  // stack, watchdog and power
  input wire logic [`CPUOP_PC_W-1:0] stack_top,
  input wire logic                   stack_pop,
  input wire logic [`CPUOP_PC_W-1:0] pc,
  input wire logic                   watchdog_clear,
  input wire logic [7:0]             watchdog_load,
  input wire logic                   osc_stop,
  input wire logic                   wake
);
  // ****************
  // execution checks
  // ****************
  // a command write lands two edges before its side-effect pulse
  wire logic cmd_wr;
  assign cmd_wr = psel && penable && pwrite && paddr == `CPUOP_OFS_CMD;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_wdog_zero:
    assert property (watchdog_clear |-> watchdog_load == `CPUOP_WDT_ZERO)
      else $error("watchdog cleared to nonzero value");
  chk_wdog_cause:
    assert property (watchdog_clear |->
      $past(cmd_wr && pwdata[3:0] == `CPUOP_OP_HALT, 2))
      else $error("watchdog clear without halt command");
  chk_sleep_entry:
    assert property ($rose(osc_stop) |-> watchdog_clear)
      else $error("sleep entered without watchdog clear");
  chk_sleep_hold:
    assert property (osc_stop && !wake |=> osc_stop)
      else $error("oscillator restarted without wake");
  chk_wake_exit:
    assert property (osc_stop && wake |=> !osc_stop)
      else $error("wake did not end sleep");
  chk_pop_cause:
    assert property (stack_pop |->
      $past(cmd_wr && pwdata[3:0] == `CPUOP_OP_RETURN, 2))
      else $error("stack pop without return command");
  chk_pop_pc:
    assert property (stack_pop |-> pc == $past(stack_top))
      else $error("pc not loaded from stack top");
  chk_pc_quiet:
    assert property ($changed(pc) |-> stack_pop)
      else $error("pc moved outside return");
  chk_pop_single:
    assert property (stack_pop |=> !stack_pop [*2])
      else $error("stack popped more than once");
  chk_bus_error:
    assert property (psel && penable && paddr[1:0] == 2'b00 |->
      pslverr == (paddr > `CPUOP_OFS_PC))
      else $error("slave error does not match address map");
endmodule

bind cpuop_exec cpuop_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .stack_top,
  .stack_pop, .pc, .watchdog_clear, .watchdog_load, .osc_stop, .wake);
`default_nettype wire
